/* common/psdc_pkg.sv */
package psdc_pkg;

  // register file addresses (4-bit registers)
  localparam logic [6:0] RF_UNLOCK_JUDGE = 7'h05;
  localparam logic [6:0] RF_UNLOCK_SENS = 7'h15;
  localparam logic [6:0] RF_MODE_SEL = 7'h21;
  localparam logic [6:0] RF_REF_SEL = 7'h31;
  // peripheral address of the 16-bit ratio register
  localparam logic [6:0] PER_RATIO = 7'h41;

  // divider mode codes held in the two low mode bits
  localparam logic [1:0] MODE_OFF = 2'h0;
  localparam logic [1:0] MODE_DIRECT = 2'h1;
  localparam logic [1:0] MODE_SWALLOW_HIGH = 2'h2;
  localparam logic [1:0] MODE_SWALLOW_LOW = 2'h3;

  // reset values
  localparam logic [3:0] NIBBLE_RST = 4'h0;
  localparam logic [1:0] MODE_BITS_RST = 2'h0;
  localparam logic [15:0] RATIO_RST = 16'h0000;

  // dual-modulus prescaler: divide by 16 or by 17 (terminal counts)
  localparam logic [4:0] PRESC_LAST_LOW = 5'h0f;
  localparam logic [4:0] PRESC_LAST_HIGH = 5'h10;
  localparam logic [4:0] PRESC_ZERO = 5'h00;
  localparam logic [11:0] PROG_LAST = 12'h001;
  localparam logic [3:0] SWALLOW_ZERO = 4'h0;

  // reference generator: twelve selectable periods in clk cycles
  localparam logic [3:0] REF_SEL_COUNT = 4'hc;
  localparam logic [15:0] REF_PERIOD [0:11] = '{
    16'h0010, 16'h0014, 16'h0019, 16'h0020, 16'h0028, 16'h0032,
    16'h0040, 16'h0050, 16'h0064, 16'h0080, 16'h00a0, 16'h00c8
  };
  localparam logic [15:0] REF_CNT_ZERO = 16'h0000;
  localparam logic [15:0] REF_CNT_ONE = 16'h0001;

  // unlock sensitivity: error pulse length, in clk cycles, that sets unlock
  localparam logic [7:0] UNLOCK_LIMIT [0:3] = '{
    8'h02, 8'h04, 8'h08, 8'h10
  };
  localparam logic [7:0] ERR_CNT_ZERO = 8'h00;
  localparam logic [7:0] ERR_CNT_ONE = 8'h01;

  // mode register layout: upper two bits fixed at zero
  typedef struct packed {
    logic [1:0] fixed_zero;
    logic [1:0] mode;
  } psdc_mode_reg_s;

  // ratio register layout
  typedef struct packed {
    logic [11:0] prog;
    logic [3:0] swallow;
  } psdc_ratio_s;

  // register file request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [6:0] addr;
    logic [3:0] wdata;
  } psdc_rf_req_s;

  // peripheral put/get request carrying the transfer buffer
  typedef struct packed {
    logic put;
    logic get;
    logic [6:0] addr;
    logic [15:0] data;
  } psdc_per_req_s;

  // three-state pin drive
  typedef struct packed {
    logic level;
    logic oe;
  } psdc_pin_s;

  // phase comparator states
  typedef enum logic [1:0] {
    PFD_IDLE,
    PFD_UP,
    PFD_DOWN
  } psdc_pfd_e;

endpackage : psdc_pkg

/* core/psdc_divider.sv */
`timescale 1ns/1ps
// programmable divider: prescaler, swallow and programmable counters
module psdc_divider (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // control
  input wire logic enable,
  input wire logic swallow_mode,
  input wire psdc_pkg::psdc_ratio_s ratio,
  // selected oscillator rising edge
  input wire logic in_edge,
  // one pulse per divided period
  output logic div_pulse
);

  // whole divider state
  typedef struct packed {
    logic [4:0] presc;
    logic [3:0] swallow;
    logic [11:0] prog;
    logic pulse;
  } psdc_div_s;

  psdc_div_s s_q;
  psdc_div_s s_d;
  logic presc_last; // prescaler at its terminal count

  // next-state logic
  always_comb begin
    s_d = s_q;
    s_d.pulse = 1'b0;
    // modulus 17 while swallow counter still nonzero
    presc_last = (s_q.swallow != psdc_pkg::SWALLOW_ZERO) ?
                 (s_q.presc == psdc_pkg::PRESC_LAST_HIGH) :
                 (s_q.presc == psdc_pkg::PRESC_LAST_LOW);
    if (!enable) begin
      // reload on restart so a new ratio takes effect at once
      s_d.presc = psdc_pkg::PRESC_ZERO;
      s_d.prog = ratio.prog;
      s_d.swallow = swallow_mode ? ratio.swallow : psdc_pkg::SWALLOW_ZERO;
    end else if (in_edge) begin
      if (!swallow_mode) begin
        // direct: programmable counter alone, swallow bypassed
        if (s_q.prog <= psdc_pkg::PROG_LAST) begin
          s_d.prog = ratio.prog;
          s_d.pulse = 1'b1;
        end else begin
          s_d.prog = s_q.prog - psdc_pkg::PROG_LAST;
        end
      end else if (presc_last) begin
        // prescaler output clocks both down-counters
        s_d.presc = psdc_pkg::PRESC_ZERO;
        if (s_q.swallow != psdc_pkg::SWALLOW_ZERO) begin
          s_d.swallow = s_q.swallow - 4'h1;
        end
        if (s_q.prog <= psdc_pkg::PROG_LAST) begin
          // period done: reload 12+4 split of the ratio
          s_d.prog = ratio.prog;
          s_d.swallow = ratio.swallow;
          s_d.pulse = 1'b1;
        end else begin
          s_d.prog = s_q.prog - psdc_pkg::PROG_LAST;
        end
      end else begin
        s_d.presc = s_q.presc + 5'h01;
      end
    end
  end

  // state register
  always_ff @(posedge clk) begin
    if (srst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign div_pulse = s_q.pulse;

endmodule : psdc_divider

/* core/psdc_top.sv */
`timescale 1ns/1ps
module psdc_top (
  // clock and power-on reset
  input wire logic clk,
  input wire logic srst,
  // clock-stop reset and chip enable pin
  input wire logic clk_stop_rst,
  input wire logic chip_enable,
  // register file access
  input wire psdc_pkg::psdc_rf_req_s rf_req,
  output logic [3:0] rf_rdata,
  // peripheral put/get access
  input wire psdc_pkg::psdc_per_req_s per_req,
  output logic [15:0] get_data,
  // oscillator inputs, sampled as synchronous levels
  input wire logic osc_in_high_band,
  input wire logic osc_in_low_band,
  // internal pull-down enables of the oscillator pins
  output logic pulldown_high_band,
  output logic pulldown_low_band,
  // charge pump three-state outputs
  output psdc_pkg::psdc_pin_s error_out_one,
  output psdc_pkg::psdc_pin_s error_out_zero
);

  // whole block state
  typedef struct packed {
    psdc_pkg::psdc_mode_reg_s mode_reg;
    logic [3:0] sens;
    logic [3:0] ref_sel;
    psdc_pkg::psdc_ratio_s ratio;
    logic unlock;
    logic [3:0] rdata;
    logic [15:0] gdata;
    logic high_prev;
    logic low_prev;
    logic [15:0] ref_cnt;
    psdc_pkg::psdc_pfd_e pfd;
    logic [7:0] err_cnt;
    psdc_pkg::psdc_pin_s eo;
    logic pd_high;
    logic pd_low;
  } psdc_top_s;

  psdc_top_s s_q;
  psdc_top_s s_d;

  logic [1:0] mode; // active division mode
  logic use_high; // high-band pin routed
  logic use_low; // low-band pin routed
  logic in_edge; // rising edge of the routed pin
  logic div_on; // divider counting
  logic div_pulse; // divided output
  logic ref_tick; // reference period end
  logic [15:0] ref_period; // selected reference period
  logic [7:0] err_limit; // tolerated error length
  logic unlock_set; // unlock event this cycle
  logic rf_judge_rd; // judge register read

  // divider instance; ratio only from the data register
  psdc_divider u_divider (
    .clk(clk),
    .srst(srst),
    .enable(div_on),
    .swallow_mode(mode[1]),
    .ratio(s_q.ratio),
    .in_edge(in_edge),
    .div_pulse(div_pulse)
  );

  // input selection and edge detection
  always_comb begin
    mode = s_q.mode_reg.mode;
    // decode of the two mode bits
    use_high = chip_enable && (mode == psdc_pkg::MODE_SWALLOW_HIGH);
    use_low = chip_enable && ((mode == psdc_pkg::MODE_DIRECT) ||
                              (mode == psdc_pkg::MODE_SWALLOW_LOW));
    // at most one pin feeds the divider
    in_edge = use_high ? (osc_in_high_band && !s_q.high_prev) :
              use_low ? (osc_in_low_band && !s_q.low_prev) : 1'b0;
    div_on = use_high || use_low;
  end

  // reference and unlock selections
  always_comb begin
    // twelve periods; other codes stop the reference
    ref_period = (s_q.ref_sel < psdc_pkg::REF_SEL_COUNT) ?
                 psdc_pkg::REF_PERIOD[s_q.ref_sel] : psdc_pkg::REF_CNT_ZERO;
    ref_tick = chip_enable && (ref_period != psdc_pkg::REF_CNT_ZERO) &&
               (s_q.ref_cnt + psdc_pkg::REF_CNT_ONE >= ref_period);
    err_limit = psdc_pkg::UNLOCK_LIMIT[s_q.sens[1:0]];
    // long error pulse means the loop lost lock
    unlock_set = (s_q.pfd != psdc_pkg::PFD_IDLE) && (s_q.err_cnt >= err_limit);
    rf_judge_rd = rf_req.rd && (rf_req.addr == psdc_pkg::RF_UNLOCK_JUDGE);
  end

  // next-state logic
  always_comb begin
    s_d = s_q;
    s_d.high_prev = osc_in_high_band;
    s_d.low_prev = osc_in_low_band;

    // register file writes
    if (rf_req.wr) begin
      unique case (rf_req.addr)
        psdc_pkg::RF_MODE_SEL: begin
          // upper bits stay zero whatever is written
          s_d.mode_reg.mode = rf_req.wdata[1:0];
        end
        psdc_pkg::RF_UNLOCK_SENS: begin
          s_d.sens = rf_req.wdata;
        end
        psdc_pkg::RF_REF_SEL: begin
          s_d.ref_sel = rf_req.wdata;
        end
        default: begin
          // judge is read-only, other addresses ignored
        end
      endcase
    end
    s_d.mode_reg.fixed_zero = '0;
    // clock-stop reset clears only the mode bits
    if (clk_stop_rst) begin
      s_d.mode_reg.mode = psdc_pkg::MODE_BITS_RST;
    end

    // register file read data, registered
    unique case (rf_req.addr)
      psdc_pkg::RF_MODE_SEL: s_d.rdata = s_q.mode_reg;
      psdc_pkg::RF_UNLOCK_SENS: s_d.rdata = s_q.sens;
      psdc_pkg::RF_REF_SEL: s_d.rdata = s_q.ref_sel;
      psdc_pkg::RF_UNLOCK_JUDGE: s_d.rdata = {3'h0, s_q.unlock};
      default: s_d.rdata = psdc_pkg::NIBBLE_RST;
    endcase

    // put loads the ratio, get returns it
    if (per_req.put && (per_req.addr == psdc_pkg::PER_RATIO)) begin
      s_d.ratio = per_req.data;
    end
    if (per_req.get && (per_req.addr == psdc_pkg::PER_RATIO)) begin
      s_d.gdata = s_q.ratio;
    end

    // judge flag: read clears, a new event in that cycle wins
    if (rf_judge_rd) begin
      s_d.unlock = 1'b0;
    end
    if (unlock_set) begin
      s_d.unlock = 1'b1;
    end

    // reference generator runs in every enabled mode
    s_d.ref_cnt = ref_tick ? psdc_pkg::REF_CNT_ZERO :
                  s_q.ref_cnt + psdc_pkg::REF_CNT_ONE;

    // phase comparator: divided edge against reference edge
    unique case (s_q.pfd)
      psdc_pkg::PFD_IDLE: begin
        if (ref_tick && !div_pulse) begin
          s_d.pfd = psdc_pkg::PFD_UP;
        end else if (div_pulse && !ref_tick) begin
          s_d.pfd = psdc_pkg::PFD_DOWN;
        end
      end
      psdc_pkg::PFD_UP: begin
        // divided edge late: pump up until it arrives
        if (div_pulse) begin
          s_d.pfd = psdc_pkg::PFD_IDLE;
        end
      end
      psdc_pkg::PFD_DOWN: begin
        if (ref_tick) begin
          s_d.pfd = psdc_pkg::PFD_IDLE;
        end
      end
      default: begin
        s_d.pfd = psdc_pkg::PFD_IDLE;
      end
    endcase
    // error length counter saturates rather than wraps
    if (s_d.pfd == psdc_pkg::PFD_IDLE) begin
      s_d.err_cnt = psdc_pkg::ERR_CNT_ZERO;
    end else if (s_q.err_cnt != 8'hff) begin
      s_d.err_cnt = s_q.err_cnt + psdc_pkg::ERR_CNT_ONE;
    end

    // chip enable low: reference, comparator and error count stopped and parked
    if (!chip_enable) begin
      s_d.ref_cnt = psdc_pkg::REF_CNT_ZERO;
      s_d.pfd = psdc_pkg::PFD_IDLE;
      s_d.err_cnt = psdc_pkg::ERR_CNT_ZERO;
    end

    // charge pump: high, low or floating
    unique case (s_d.pfd)
      psdc_pkg::PFD_UP: s_d.eo = '{level: 1'b1, oe: 1'b1};
      psdc_pkg::PFD_DOWN: s_d.eo = '{level: 1'b0, oe: 1'b1};
      default: s_d.eo = '{level: 1'b0, oe: 1'b0};
    endcase

    // pull down any pin not routed
    s_d.pd_high = !(chip_enable &&
                    (s_d.mode_reg.mode == psdc_pkg::MODE_SWALLOW_HIGH));
    s_d.pd_low = !(chip_enable &&
                   ((s_d.mode_reg.mode == psdc_pkg::MODE_DIRECT) ||
                    (s_d.mode_reg.mode == psdc_pkg::MODE_SWALLOW_LOW)));
  end

  // state register; power-on clears mode and all else, pull-downs set
  always_ff @(posedge clk) begin
    if (srst) begin
      s_q <= '{
        mode_reg: '{fixed_zero: 2'h0, mode: psdc_pkg::MODE_BITS_RST},
        sens: psdc_pkg::NIBBLE_RST,
        ref_sel: psdc_pkg::NIBBLE_RST,
        ratio: psdc_pkg::RATIO_RST,
        unlock: 1'b0,
        rdata: psdc_pkg::NIBBLE_RST,
        gdata: psdc_pkg::RATIO_RST,
        high_prev: 1'b0,
        low_prev: 1'b0,
        ref_cnt: psdc_pkg::REF_CNT_ZERO,
        pfd: psdc_pkg::PFD_IDLE,
        err_cnt: psdc_pkg::ERR_CNT_ZERO,
        eo: '{level: 1'b0, oe: 1'b0},
        pd_high: 1'b1,
        pd_low: 1'b1
      };
    end else begin
      s_q <= s_d;
    end
  end

  // outputs straight from the state register
  assign rf_rdata = s_q.rdata;
  assign get_data = s_q.gdata;
  assign pulldown_high_band = s_q.pd_high;
  assign pulldown_low_band = s_q.pd_low;
  // both error pins carry the same pump drive
  assign error_out_one = s_q.eo;
  assign error_out_zero = s_q.eo;

endmodule : psdc_top

/* testbench/psdc_checker.sv */
`timescale 1ns/1ps
// pin-level watcher for the synthesizer control block
module psdc_checker (
  // clock and power-on reset
  input wire logic clk,
  input wire logic srst,
  // control pins
  input wire logic clk_stop_rst,
  input wire logic chip_enable,
  // register and put/get access
  input wire psdc_pkg::psdc_rf_req_s rf_req,
  input wire logic [3:0] rf_rdata,
  input wire psdc_pkg::psdc_per_req_s per_req,
  input wire logic [15:0] get_data,
  // oscillator side
  input wire logic osc_in_high_band,
  input wire logic osc_in_low_band,
  input wire logic pulldown_high_band,
  input wire logic pulldown_low_band,
  input wire psdc_pkg::psdc_pin_s error_out_one,
  input wire psdc_pkg::psdc_pin_s error_out_zero
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  // mode write seen this cycle
  logic mode_wr;
  // code written last cycle, kept for the pin check
  logic [1:0] code_q;
  assign mode_wr = rf_req.wr && rf_req.addr == psdc_pkg::RF_MODE_SEL;
  // capture written code
  always_ff @(posedge clk) begin
    code_q <= rf_req.wdata[1:0];
  end
  property p_off_pulls;
    !chip_enable |=> pulldown_high_band && pulldown_low_band;
  endproperty
  a_off_pulls: assert property (p_off_pulls)
    else $error("pins not pulled down while disabled");
  property p_off_float;
    !chip_enable [*3] |-> !error_out_one.oe;
  endproperty
  a_off_float: assert property (p_off_float)
    else $error("error output driven while disabled");
  property p_mode_pins;
    mode_wr && chip_enable && !clk_stop_rst |=>
      pulldown_high_band == (code_q != psdc_pkg::MODE_SWALLOW_HIGH) &&
      pulldown_low_band == !code_q[0];
  endproperty
  a_mode_pins: assert property (p_mode_pins)
    else $error("pull-downs do not follow mode code");
  property p_one_pin;
    pulldown_high_band || pulldown_low_band;
  endproperty
  a_one_pin: assert property (p_one_pin)
    else $error("both oscillator pins selected");
  property p_pins_same;
    error_out_one == error_out_zero;
  endproperty
  a_pins_same: assert property (p_pins_same)
    else $error("error outputs differ");
  property p_upper_zero;
    rf_req.addr == psdc_pkg::RF_MODE_SEL |=> rf_rdata[3:2] == 2'h0;
  endproperty
  a_upper_zero: assert property (p_upper_zero)
    else $error("mode upper bits not zero");
  sequence s_put_get;
    per_req.put && per_req.addr == psdc_pkg::PER_RATIO ##1
      per_req.get && per_req.addr == psdc_pkg::PER_RATIO;
  endsequence
  property p_put_get;
    s_put_get |=> get_data == $past(per_req.data, 2);
  endproperty
  a_put_get: assert property (p_put_get)
    else $error("get does not return put ratio");
  property p_get_hold;
    !per_req.get |=> $stable(get_data);
  endproperty
  a_get_hold: assert property (p_get_hold)
    else $error("get data moved without get");
  property p_stop_clear;
    clk_stop_rst && !rf_req.wr |=> pulldown_high_band && pulldown_low_band;
  endproperty
  a_stop_clear: assert property (p_stop_clear)
    else $error("clock-stop reset left a pin selected");
  // main scenarios reached
  c_mode: cover property (mode_wr && chip_enable);
  c_put_get: cover property (s_put_get);
  c_stop: cover property (clk_stop_rst);
endmodule : psdc_checker

bind psdc_top psdc_checker u_chk (
  .clk(clk), .srst(srst), .clk_stop_rst(clk_stop_rst),
  .chip_enable(chip_enable), .rf_req(rf_req), .rf_rdata(rf_rdata),
  .per_req(per_req), .get_data(get_data),
  .osc_in_high_band(osc_in_high_band), .osc_in_low_band(osc_in_low_band),
  .pulldown_high_band(pulldown_high_band),
  .pulldown_low_band(pulldown_low_band),
  .error_out_one(error_out_one), .error_out_zero(error_out_zero)
);

/* testbench/psdc_top_tb.sv */
`timescale 1ns/1ps
// self-checking bench for the synthesizer control block
module psdc_top_tb;
  logic clk, srst, clk_stop_rst, chip_enable; // clock and control
  psdc_pkg::psdc_rf_req_s rf_req; // register request
  psdc_pkg::psdc_per_req_s per_req; // put/get request
  logic [3:0] rf_rdata, half, rv; // read data, vco half period, scratch
  logic [15:0] get_data, gv, r; // get data and scratch
  logic osc_h, osc_l, pd_h, pd_l, seen; // oscillator side
  psdc_pkg::psdc_pin_s eo1, eo0; // charge pump pins
  int errors, cmp_count, cycles, mode_m, i; // counters and model
  logic [15:0] ratio_q[$]; // model of the ratio register
  psdc_top DUT (.clk(clk), .srst(srst), .clk_stop_rst(clk_stop_rst),
    .chip_enable(chip_enable), .rf_req(rf_req), .rf_rdata(rf_rdata),
    .per_req(per_req), .get_data(get_data), .osc_in_high_band(osc_h),
    .osc_in_low_band(osc_l), .pulldown_high_band(pd_h),
    .pulldown_low_band(pd_l), .error_out_one(eo1), .error_out_zero(eo0));
  psdc_vco_model u_vco (.clk(clk), .half_period(half),
    .pulldown_high_band(pd_h), .pulldown_low_band(pd_l),
    .osc_in_high_band(osc_h), .osc_in_low_band(osc_l));
  // compare and count
  task automatic check(string name, logic [15:0] got, logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask : check
  // verdict
  task automatic finish_test();
    $display("checks %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : finish_test
  // register write, mode copied into the model
  task automatic rf_write(logic [6:0] a, logic [3:0] d);
    @(posedge clk) rf_req <= '{1'b1, 1'b0, a, d};
    @(posedge clk) rf_req.wr <= 1'b0;
    #1;
    if (a == psdc_pkg::RF_MODE_SEL) mode_m = int'(d[1:0]);
  endtask : rf_write
  // register read, data one edge after the address
  task automatic rf_read(logic [6:0] a, output logic [3:0] d);
    @(posedge clk) rf_req.addr <= a;
    @(posedge clk);
    #1 d = rf_rdata;
  endtask : rf_read
  // put to any address, get from the ratio register next cycle
  task automatic put_get(logic [6:0] a, logic [15:0] d);
    @(posedge clk) per_req <= '{1'b1, 1'b0, a, d};
    @(posedge clk) per_req <= '{1'b0, 1'b1, psdc_pkg::PER_RATIO, d};
    @(posedge clk) per_req.get <= 1'b0;
    #1;
    if (a == psdc_pkg::PER_RATIO) ratio_q[0] = d;
    check("get_data", get_data, ratio_q[0]);
  endtask : put_get
  // pull-downs against the mode model
  task automatic check_pins();
    check("pd_high", pd_h, !(chip_enable && mode_m == 2));
    check("pd_low", pd_l, !(chip_enable && mode_m[0]));
  endtask : check_pins
  // 50 MHz clock
  initial begin
    clk = 1'b0;
    forever #10 clk = !clk;
  end
  // hang guard, far above the expected run
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      finish_test();
    end
  end
  // main sequence
  initial begin
    srst = 1'b1;
    clk_stop_rst = 1'b0;
    chip_enable = 1'b0;
    rf_req = '0;
    per_req = '0;
    half = 4'h3;
    mode_m = 0;
    ratio_q.push_back(psdc_pkg::RATIO_RST);
    i = $urandom(19215);
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    chip_enable <= 1'b1;
    // reset values and an unmapped read
    rf_read(psdc_pkg::RF_MODE_SEL, rv);
    check("mode_rst", rv, psdc_pkg::NIBBLE_RST);
    check_pins();
    rf_read(7'h7f, rv);
    check("unmapped", rv, 4'h0);
    $display("test reset done");
    // every mode code, junk in the fixed bits
    for (i = 0; i < 8; i++) begin
      half <= 4'($urandom_range(1, 7));
      rf_write(psdc_pkg::RF_MODE_SEL, {2'($urandom), 2'(i)});
      check_pins();
      rf_read(psdc_pkg::RF_MODE_SEL, rv);
      check("mode_rd", rv, {2'h0, 2'(mode_m)});
    end
    $display("test modes done");
    // ratio put/get back to back, stray address ignored
    for (i = 0; i < 6; i++) begin
      // direct-mode legal range kept by software
      r = {12'($urandom_range(16, 4095)), 4'($urandom)};
      put_get(i[0] ? 7'h40 : psdc_pkg::PER_RATIO, r);
    end
    $display("test ratio done");
    // clock-stop reset clears mode, chip enable keeps it
    rf_write(psdc_pkg::RF_MODE_SEL, 4'h3);
    @(posedge clk) clk_stop_rst <= 1'b1;
    @(posedge clk) clk_stop_rst <= 1'b0;
    #1 mode_m = 0;
    check_pins();
    rf_write(psdc_pkg::RF_MODE_SEL, 4'h2);
    @(posedge clk) chip_enable <= 1'b0;
    repeat (4) @(posedge clk);
    #1 check_pins();
    check("oe_off", eo1.oe, 1'b0);
    rf_read(psdc_pkg::RF_MODE_SEL, rv);
    check("mode_kept", rv, 4'h2);
    @(posedge clk) chip_enable <= 1'b1;
    $display("test resets done");
    // inputs off: reference and pump still run, pump drives up
    rf_write(psdc_pkg::RF_REF_SEL, 4'h0);
    rf_write(psdc_pkg::RF_MODE_SEL, 4'h0);
    check_pins();
    seen = 1'b0;
    for (i = 0; i < 600 && !seen; i++) begin
      @(posedge clk);
      #1 seen = eo1.oe && eo1.level;
    end
    check("pump_up", seen, 1'b1);
    // long pump-up pulse must have raised the unlock flag
    rf_read(psdc_pkg::RF_UNLOCK_JUDGE, rv);
    check("unlock", rv, 4'h1);
    $display("test inputs off done");
    // direct division, slow reference: divided edge first, pump down
    @(posedge clk) half <= 4'h1;
    put_get(psdc_pkg::PER_RATIO, 16'h0100);
    rf_write(psdc_pkg::RF_REF_SEL, 4'hb);
    rf_write(psdc_pkg::RF_MODE_SEL, 4'h1);
    check_pins();
    seen = 1'b0;
    for (i = 0; i < 600 && !seen; i++) begin
      @(posedge clk);
      #1 seen = eo1.oe && !eo1.level;
    end
    check("pump_down", seen, 1'b1);
    $display("test direct done");
    finish_test();
  end
endmodule : psdc_top_tb

/* testbench/psdc_vco_model.sv */
`timescale 1ns/1ps
// external oscillator; a pulled-down pin reads low, not a stale level
module psdc_vco_model (
  // clock
  input wire logic clk,
  // oscillation half period minus one, in clk cycles
  input wire logic [3:0] half_period,
  // pull-down enables from the block
  input wire logic pulldown_high_band,
  input wire logic pulldown_low_band,
  // oscillator levels
  output logic osc_in_high_band,
  output logic osc_in_low_band
);
  int cnt = 0; // cycles in current half period
  logic level = 1'b0; // free-running oscillator level
  // free-running square wave
  always @(posedge clk) begin
    cnt <= cnt + 1;
    if (cnt >= int'(half_period)) begin
      cnt <= 0;
      level <= !level;
    end
  end
  // pulled pin goes to its pull level
  assign osc_in_high_band = pulldown_high_band ? 1'b0 : level;
  assign osc_in_low_band = pulldown_low_band ? 1'b0 : !level;
endmodule : psdc_vco_model
